// [src/bbs_pkg.sv]
/*
  Package for the billboard attach sequencer: register offsets, reset values,
  control field layout, timing constants and the sequencer state type.
  Assumes a 250 MHz system clock and an APB slave with 32-bit data.
*/
package bbs_pkg;

  // Register indices; each register owns one word, its byte address is four times the index
  localparam logic [15:0] IDX_TMR_A_LOW  = 16'h413c;
  localparam logic [15:0] IDX_TMR_A_HIGH = 16'h413d;
  localparam logic [15:0] IDX_TMR_B_LOW  = 16'h413e;
  localparam logic [15:0] IDX_TMR_B_HIGH = 16'h413f;
  localparam logic [15:0] IDX_CONTROL    = 16'h4140;
  localparam logic [15:0] IDX_STATUS     = 16'h4141;

  localparam int          ADDR_W         = 18;

  // Reset values
  localparam logic [7:0]  RST_TMR_A_LOW  = 8'hd0;
  localparam logic [7:0]  RST_TMR_A_HIGH = 8'h07;
  localparam logic [7:0]  RST_TMR_B_LOW  = 8'hd0;
  localparam logic [7:0]  RST_TMR_B_HIGH = 8'h07;
  localparam logic [7:0]  RST_CONTROL    = 8'h14;

  // Control byte fields
  localparam int          CTL_EN_BIT     = 0;
  localparam int          CTL_SEL_LSB    = 1;
  localparam int          CTL_SEL_W      = 5;
  localparam logic [7:0]  CTL_WR_MASK    = 8'h3f;

  // Failure pin count and the error code reported for the configured field
  localparam int          NUM_GPIO       = 32;
  localparam logic [1:0]  CFG_ERR_CODE   = 2'h0;

  // Billboard class version, BCD
  localparam logic [15:0] BB_VERSION     = 16'h0110;

  // Timing
  localparam int          CLK_MHZ        = 250;
  localparam int          TICK_MS        = 10;
  localparam int          TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
  localparam int          DETACH_CYCLES  = 16;

  // Status bit positions
  localparam int          ST_BB_BIT      = 0;
  localparam int          ST_DETACH_BIT  = 1;
  localparam int          ST_TA_BIT      = 2;
  localparam int          ST_TB_BIT      = 3;

  typedef enum logic [2:0] {
    BBS_NORMAL,
    BBS_DETACH_IN,
    BBS_BILLBOARD,
    BBS_DETACH_OUT,
    BBS_WAIT_RELEASE
  } bbs_state_t;

  // Events from the internal function
  typedef struct packed {
    logic addr_set;
    logic alt_str_req;
  } bbs_host_evt_t;

  // Personality presented to the internal function
  typedef struct packed {
    logic        detach;
    logic        billboard;
    logic [15:0] bb_version;
    logic [1:0]  cfg_code;
  } bbs_persona_t;

endpackage

// [src/bbs_sequencer.sv]
/*
  Billboard attach sequencer: swaps the internal function between its normal
  and billboard personality on an alternate mode failure and detaches it
  again when a detach timer runs out.
  Assumes the failure pins are synchronous to sys_clk_i and that the
  internal function acts on the detach and personality outputs.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// R01 - A low level on the selected failure pin forces the internal function to detach.
// R02 - After that detach the function reattaches as a billboard device of version 1.1.
// R03 - Timer A starts when the host sets the function address in billboard mode.
// R04 - Billboard is shown only on failure, and the configured field reports code 00b.
// R05 - A host request for the alternate mode string starts Timer B.
// R06 - Expiry of either timer forces the function to detach again.
// R07 - After the expiry detach the function reattaches with its standard personality.
// R08 - Each timeout is a 16-bit count of 10 ms units from a low and a high byte.
// R09 - Timer A bytes reset to D0h and 07h, a 20 second timeout.
// R10 - Timer B also defaults to a 20 second timeout.
// R11 - The power delivery controller drives the selected pin low to report failure.
// R12 - The behaviour runs only while control bit 0 is set; the bit only gates failure detection, so an episode under way runs on.
// R13 - Control bits 5 to 1 select the failure pin, 01010 by default.
// R14 - Timers count on a 10 ms tick and clear when the standard personality returns.
module bbs_sequencer #(
  parameter int TICK_CYCLES = bbs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                            sys_clk_i,
  input  wire logic                            sys_rst_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [bbs_pkg::ADDR_W-1:0]      paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  input  wire logic [3:0]                      pstrb_i,
  output logic                                 pready_o,
  output logic [31:0]                          prdata_o,
  output logic                                 pslverr_o,
  // Failure pins from the power delivery controller, active low
  input  wire logic [bbs_pkg::NUM_GPIO-1:0]    gpio_fail_n_i,
  // Events from the internal function
  input  wire bbs_pkg::bbs_host_evt_t          host_evt_i,
  // Personality to the internal function
  output bbs_pkg::bbs_persona_t                persona_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  localparam int ADDR_W_L = bbs_pkg::ADDR_W;

  function automatic logic [ADDR_W_L-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]          tmr_a_low_reg;
  logic [7:0]          tmr_a_high_reg;
  logic [7:0]          tmr_b_low_reg;
  logic [7:0]          tmr_b_high_reg;
  logic [7:0]          control_reg;
  bbs_pkg::bbs_state_t state_reg;
  bbs_pkg::bbs_state_t state_next;
  logic [31:0]         tick_cnt_reg;
  logic                tick;
  logic [15:0]         cnt_a_reg;
  logic [15:0]         cnt_b_reg;
  logic                run_a_reg;
  logic                run_b_reg;
  logic [4:0]          det_cnt_reg;
  logic                exp_a;
  logic                exp_b;
  logic                fail_seen;
  logic                enabled;
  logic [4:0]          pin_sel;
  logic                wr_en;
  logic                rd_en;
  logic                addr_hit;
  logic [7:0]          rd_byte;
  logic [7:0]          status;

  assign enabled   = control_reg[bbs_pkg::CTL_EN_BIT];                       // R12
  assign pin_sel   = control_reg[bbs_pkg::CTL_SEL_LSB +: bbs_pkg::CTL_SEL_W]; // R13
  assign fail_seen = enabled && !gpio_fail_n_i[pin_sel];                    // R01 R11

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  assign pready_o = 1'b1;
  assign wr_en    = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign rd_en    = psel_i && penable_i && !pwrite_i;

  always_comb begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_A_LOW)) begin
      rd_byte = tmr_a_low_reg;
    end else if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_A_HIGH)) begin
      rd_byte = tmr_a_high_reg;
    end else if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_B_LOW)) begin
      rd_byte = tmr_b_low_reg;
    end else if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_B_HIGH)) begin
      rd_byte = tmr_b_high_reg;
    end else if (paddr_i == reg_addr(bbs_pkg::IDX_CONTROL)) begin
      rd_byte = control_reg;
    end else if (paddr_i == reg_addr(bbs_pkg::IDX_STATUS)) begin
      rd_byte = status;
    end else begin
      addr_hit = 1'b0;
    end
  end

  assign pslverr_o = psel_i && penable_i && !addr_hit;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tmr_a_low_reg  <= bbs_pkg::RST_TMR_A_LOW;   // R09
      tmr_a_high_reg <= bbs_pkg::RST_TMR_A_HIGH;  // R09
      tmr_b_low_reg  <= bbs_pkg::RST_TMR_B_LOW;   // R10
      tmr_b_high_reg <= bbs_pkg::RST_TMR_B_HIGH;  // R10
      control_reg    <= bbs_pkg::RST_CONTROL;     // R13
    end else if (wr_en) begin
      if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_A_LOW)) begin
        tmr_a_low_reg <= pwdata_i[7:0];
      end else if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_A_HIGH)) begin
        tmr_a_high_reg <= pwdata_i[7:0];
      end else if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_B_LOW)) begin
        tmr_b_low_reg <= pwdata_i[7:0];
      end else if (paddr_i == reg_addr(bbs_pkg::IDX_TMR_B_HIGH)) begin
        tmr_b_high_reg <= pwdata_i[7:0];
      end else if (paddr_i == reg_addr(bbs_pkg::IDX_CONTROL)) begin
        // Reserved bits 7:6 stay zero
        control_reg <= pwdata_i[7:0] & bbs_pkg::CTL_WR_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bbs_pkg::BBS_NORMAL: begin
        if (fail_seen) begin
          state_next = bbs_pkg::BBS_DETACH_IN;                              // R01
        end
      end
      bbs_pkg::BBS_DETACH_IN: begin
        if (det_cnt_reg == 5'(bbs_pkg::DETACH_CYCLES - 1)) begin
          state_next = bbs_pkg::BBS_BILLBOARD;                              // R02
        end
      end
      bbs_pkg::BBS_BILLBOARD: begin
        if (exp_a || exp_b) begin
          state_next = bbs_pkg::BBS_DETACH_OUT;                             // R06
        end
      end
      bbs_pkg::BBS_DETACH_OUT: begin
        if (det_cnt_reg == 5'(bbs_pkg::DETACH_CYCLES - 1)) begin
          state_next = bbs_pkg::BBS_WAIT_RELEASE;                           // R07
        end
      end
      bbs_pkg::BBS_WAIT_RELEASE: begin
        // Avoid re-entering billboard at once while the pin is still low
        if (!fail_seen) begin
          state_next = bbs_pkg::BBS_NORMAL;
        end
      end
      default: begin
        state_next = bbs_pkg::BBS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= bbs_pkg::BBS_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      det_cnt_reg <= 5'h00;
    end else if (state_reg == bbs_pkg::BBS_DETACH_IN || state_reg == bbs_pkg::BBS_DETACH_OUT) begin
      det_cnt_reg <= (state_next == state_reg) ? det_cnt_reg + 5'h01 : 5'h00;
    end else begin
      det_cnt_reg <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ten millisecond tick, free running only while in billboard mode

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (state_reg != bbs_pkg::BBS_BILLBOARD) begin
      tick_cnt_reg <= 32'h0000_0000;                                         // R14
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));                     // R14

  ////////////////////////////////////////////////////////////////////////////
  // Detach timers, 10 ms units loaded from the byte pairs

  assign exp_a = run_a_reg && tick && (cnt_a_reg <= 16'h0001);
  assign exp_b = run_b_reg && tick && (cnt_b_reg <= 16'h0001);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_a_reg <= 1'b0;
      cnt_a_reg <= 16'h0000;
    end else if (state_reg != bbs_pkg::BBS_BILLBOARD) begin
      run_a_reg <= 1'b0;                                                    // R14
      cnt_a_reg <= 16'h0000;
    end else if (host_evt_i.addr_set && !run_a_reg) begin
      run_a_reg <= 1'b1;                                                    // R03
      cnt_a_reg <= {tmr_a_high_reg, tmr_a_low_reg};                         // R08
    end else if (run_a_reg && tick && cnt_a_reg != 16'h0000) begin
      cnt_a_reg <= cnt_a_reg - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_b_reg <= 1'b0;
      cnt_b_reg <= 16'h0000;
    end else if (state_reg != bbs_pkg::BBS_BILLBOARD) begin
      run_b_reg <= 1'b0;                                                    // R14
      cnt_b_reg <= 16'h0000;
    end else if (host_evt_i.alt_str_req && !run_b_reg) begin
      run_b_reg <= 1'b1;                                                    // R05
      cnt_b_reg <= {tmr_b_high_reg, tmr_b_low_reg};                         // R08
    end else if (run_b_reg && tick && cnt_b_reg != 16'h0000) begin
      cnt_b_reg <= cnt_b_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      persona_o <= '0;
    end else begin
      persona_o.detach     <= (state_next == bbs_pkg::BBS_DETACH_IN)
                           || (state_next == bbs_pkg::BBS_DETACH_OUT);      // R01 R06
      persona_o.billboard  <= (state_next == bbs_pkg::BBS_BILLBOARD);       // R02 R04 R07
      persona_o.bb_version <= bbs_pkg::BB_VERSION;                          // R02
      persona_o.cfg_code   <= bbs_pkg::CFG_ERR_CODE;                        // R04
    end
  end

  assign status = {4'h0, run_b_reg, run_a_reg, persona_o.detach, persona_o.billboard};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence fail_low_s;
    enabled && !gpio_fail_n_i[pin_sel] && state_reg == bbs_pkg::BBS_NORMAL;
  endsequence

  fail_detach_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R01
    fail_low_s |=> persona_o.detach)
    else $error("Failure pin did not force detach");

  detach_billboard_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R02
    $rose(persona_o.detach) && state_reg == bbs_pkg::BBS_DETACH_IN |-> ##16 persona_o.billboard)
    else $error("No billboard reattach after detach");

  timer_a_start_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R03
    state_reg == bbs_pkg::BBS_BILLBOARD && host_evt_i.addr_set && !run_a_reg
    |=> run_a_reg && cnt_a_reg == {$past(tmr_a_high_reg), $past(tmr_a_low_reg)})
    else $error("Timer A did not start on address set");

  cfg_code_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R04
    persona_o.billboard |-> persona_o.cfg_code == 2'h0 && !persona_o.detach)
    else $error("Configured code wrong in billboard mode");

  timer_b_start_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R05
    state_reg == bbs_pkg::BBS_BILLBOARD && host_evt_i.alt_str_req && !run_b_reg |=> run_b_reg)
    else $error("Timer B did not start on string request");

  expiry_detach_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R06
    state_reg == bbs_pkg::BBS_BILLBOARD && (exp_a || exp_b)
    |=> persona_o.detach ##16 !persona_o.detach)
    else $error("Timer expiry did not detach");

  normal_return_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R07
    state_reg == bbs_pkg::BBS_DETACH_OUT |-> !persona_o.billboard)
    else $error("Billboard persona after expiry detach");

  disabled_idle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R12
    !enabled && state_reg == bbs_pkg::BBS_NORMAL |=> state_reg == bbs_pkg::BBS_NORMAL)
    else $error("Sequencer left normal while disabled");

  timer_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R14
    state_reg != bbs_pkg::BBS_BILLBOARD |=> !run_a_reg && !run_b_reg && tick_cnt_reg == 32'h0)
    else $error("Timers not cleared outside billboard mode");

endmodule

// [testbench/bbs_far_model.sv]
/*
  Far side model: the power delivery controller that reports an alternate
  mode failure on one active low pin, and the host that sets the function
  address and asks for the alternate mode string.
  Assumes the bench gives commands right after a rising clock edge.
*/
`timescale 1ns/1ps

module bbs_far_model (
  // Clock
  input  wire logic                    sys_clk_i,
  // Commands from the bench
  input  wire logic                    fail_i,
  input  wire logic [4:0]              pin_i,
  input  wire logic                    addr_set_i,
  input  wire logic                    str_req_i,
  // Lines towards the device
  output logic [31:0]                  gpio_fail_n_o,
  output bbs_pkg::bbs_host_evt_t       host_evt_o
);
  // Idle pins sit at their pull-up level; only the reporting pin is pulled low
  always @(posedge sys_clk_i) begin
    gpio_fail_n_o          <= fail_i ? ~(32'h0000_0001 << pin_i) : 32'hffff_ffff;
    host_evt_o.addr_set    <= addr_set_i;
    host_evt_o.alt_str_req <= str_req_i;
  end
endmodule

// [testbench/billboard_attach_sequencer_test.sv]
/*
  Self-checking bench for the billboard attach sequencer: APB register
  checks against a mirror, then a failure and timer expiry run per timer.
  Assumes a shortened tick of 10 cycles; the APB master waits for pready.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (e)); end end

module billboard_attach_sequencer_test;
  localparam int TICK = 10;
  logic                   sys_clk_i = 1'b0;
  logic                   sys_rst_i = 1'b1;
  logic                   psel      = 1'b0;
  logic                   penable   = 1'b0;
  logic                   pwrite    = 1'b0;
  logic [17:0]            paddr     = '0;
  logic [31:0]            pwdata    = '0;
  logic [3:0]             pstrb     = '0;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  logic [31:0]            gpio_n;
  bbs_pkg::bbs_host_evt_t evt;
  bbs_pkg::bbs_persona_t  persona;
  logic                   fail      = 1'b0;
  logic [4:0]             pin       = 5'h0a;
  logic                   a_set     = 1'b0;
  logic                   s_req     = 1'b0;
  int                     failures  = 0;
  int                     check_count = 0;
  logic [31:0]            seed      = 32'h3e68;
  logic [31:0]            rd;
  logic                   err;
  // Register mirror: timer A low/high, timer B low/high, control
  logic [7:0]             mirror [5] = '{8'hd0, 8'h07, 8'hd0, 8'h07, 8'h14};

  always #2 sys_clk_i = ~sys_clk_i;

  bbs_sequencer #(.TICK_CYCLES(TICK)) i_dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .gpio_fail_n_i(gpio_n), .host_evt_i(evt), .persona_o(persona));

  bbs_far_model i_far (
    .sys_clk_i(sys_clk_i), .fail_i(fail), .pin_i(pin), .addr_set_i(a_set),
    .str_req_i(s_req), .gpio_fail_n_o(gpio_n), .host_evt_o(evt));

  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic [15:0] idx, input logic w, input logic [7:0] d);
    logic [31:0] r;
    r = xs();
    psel    <= 1'b1;
    paddr   <= {idx, 2'b00};
    pwrite  <= w;
    pwdata  <= {r[23:0], d};
    pstrb   <= 4'hf;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
    // Upper control bits are reserved and read back as zero
    if (idx == bbs_pkg::IDX_CONTROL) d = d & bbs_pkg::CTL_WR_MASK;
    mirror[idx - bbs_pkg::IDX_TMR_A_LOW] = d;
  endtask

  task automatic rd_chk(input logic [15:0] idx);
    apb(idx, 1'b0, 8'h00);
    `CHK(rd, {24'h00_0000, mirror[idx - bbs_pkg::IDX_TMR_A_LOW]})
  endtask

  task automatic wait_p(input logic det, input logic bb, output int n);
    n = 0;
    while (!(persona.detach === det && persona.billboard === bb) && n < 5000) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  // One failure episode ended by timer A (t=0) or timer B (t=1)
  task automatic run(input int t);
    int          n;
    int          ticks;
    logic [31:0] r;
    logic [4:0]  p;
    logic [7:0]  lo;
    logic [7:0]  hi;
    r = xs();
    p = r[4:0];
    lo = {5'h00, r[10:8]} + 8'h02;
    hi = (t == 1) ? 8'h01 : 8'h00;
    ticks = {hi, lo};
    wr(bbs_pkg::IDX_CONTROL, {r[7:6], p, 1'b1});
    rd_chk(bbs_pkg::IDX_CONTROL);
    wr(bbs_pkg::IDX_TMR_A_LOW + 16'(2 * t), lo);
    wr(bbs_pkg::IDX_TMR_A_HIGH + 16'(2 * t), hi);
    fail <= 1'b1;
    pin <= p + 5'h01;
    repeat (20) @(posedge sys_clk_i);
    `CHK(persona.detach, 1'b0)
    pin <= p;
    @(posedge sys_clk_i);
    wait_p(1'b1, 1'b0, n);
    `CHK(n <= 3, 1'b1)
    wait_p(1'b0, 1'b1, n);
    `CHK(n, 16)
    `CHK(persona.bb_version, 16'h0110)
    `CHK(persona.cfg_code, 2'b00)
    // Status: billboard shown, no detach, no timer running yet
    apb(bbs_pkg::IDX_STATUS, 1'b0, 8'h00);
    `CHK(rd, 32'h0000_0001)
    if (t == 0) a_set <= 1'b1;
    else s_req <= 1'b1;
    @(posedge sys_clk_i);
    a_set <= 1'b0;
    s_req <= 1'b0;
    wait_p(1'b1, 1'b0, n);
    `CHK(n >= (ticks - 1) * TICK && n <= ticks * TICK + 4, 1'b1)
    wait_p(1'b0, 1'b0, n);
    `CHK(n, 16)
    // Pin still low must not retrigger the billboard
    repeat (20) @(posedge sys_clk_i);
    `CHK({persona.detach, persona.billboard}, 2'b00)
    fail <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    $display("case %0d done, ticks %0d", t, ticks);
  endtask

  task print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    `CHK({persona.detach, persona.billboard}, 2'b00)
    for (int i = 0; i < 5; i++) rd_chk(bbs_pkg::IDX_TMR_A_LOW + 16'(i));
    apb(bbs_pkg::IDX_STATUS + 16'h0001, 1'b0, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wr(bbs_pkg::IDX_TMR_A_LOW + 16'(i), r[7:0]);
      rd_chk(bbs_pkg::IDX_TMR_A_LOW + 16'(i));
    end
    $display("register test done");
    // Feature off: a low default pin must leave the function alone
    fail <= 1'b1;
    repeat (30) @(posedge sys_clk_i);
    `CHK(persona.detach, 1'b0)
    fail <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    $display("disabled test done");
    for (int t = 0; t < 2; t++) run(t);
    print_verdict();
  end
endmodule
